// ### include/oms_pkg.sv
// Package for the operating-mode sequencer: modes, phases, timing constants.
// Assumes a single 10 MHz system clock shared by every user of the package.
package oms_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned RUN_BLINK_MIN_MS = 3000;
   localparam int unsigned WATCHDOG_MS = 100;
   localparam int unsigned CYCLE_MON_MIN_MS = 1;
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned MR_HOLD_MS = 3000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned RUN_BLINK_CYC = RUN_BLINK_MIN_MS * CYC_PER_MS;
   localparam int unsigned WATCHDOG_CYC = WATCHDOG_MS * CYC_PER_MS;
   localparam int unsigned CYCLE_MON_MIN_CYC = CYCLE_MON_MIN_MS * CYC_PER_MS;
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
   localparam int unsigned MR_HOLD_CYC = MR_HOLD_MS * CYC_PER_MS;

   // ------------------------------------------------------------------
   // Limits and codes
   // ------------------------------------------------------------------
   localparam int unsigned MAX_BREAKPOINTS = 3;
   localparam int unsigned STEP_MAX_BREAKPOINTS = 2;
   localparam logic [1:0] MODE_STOP = 2'h0;
   localparam logic [1:0] MODE_STARTUP = 2'h1;
   localparam logic [1:0] MODE_RUN = 2'h2;
   localparam logic [1:0] MODE_HOLD = 2'h3;

   // Operating modes.
   typedef enum logic [1:0] {
      OMS_STOP, OMS_STARTUP, OMS_RUN, OMS_HOLD
   } oms_mode_t;

   // Phases of work ordered for the program engine.
   typedef enum logic [2:0] {
      PH_IDLE, PH_CLR_IN, PH_STARTUP, PH_CLR_OUT, PH_READ_IN, PH_MAIN,
      PH_WRITE_OUT
   } oms_phase_t;

   // Indicator outputs travel together.
   typedef struct packed {
      logic run_led;
      logic stop_led;
   } oms_leds_t;

   // Analog output range kinds.
   typedef enum logic [1:0] {
      AO_VOLT, AO_0_20MA, AO_4_20MA
   } oms_ao_kind_t;

endpackage : oms_pkg

// ### hdl/oms_timer.sv
// Down-counting timer with load, hold and expiry flag.
// Assumes a synchronous single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module oms_timer #(
   parameter int unsigned WIDTH = 32
) (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Control.
   input wire logic load_in,
   input wire logic [WIDTH-1:0] load_value_in,
   input wire logic run_in,
   // Status.
   output logic expired_out,
   output logic busy_out
);

   initial begin
      if (WIDTH < 2) $error("oms_timer: WIDTH too small");
   end

   logic [WIDTH-1:0] count;

   // Load wins over counting so a restart is never lost.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count <= '0;
      end else if (load_in) begin
         count <= load_value_in;
      end else if (run_in && count != '0) begin
         count <= count - WIDTH'(1);
      end
   end

   assign busy_out = (count != '0);
   assign expired_out = (count == WIDTH'(1)) && run_in && !load_in;

endmodule : oms_timer
`default_nettype wire

// ### hdl/oms_sequencer.sv
// Operating-mode sequencer: stop, start-up, run and hold with watchdogs.
// Assumes a program engine that acknowledges each ordered phase with a
// one-cycle done pulse and reports breakpoint hits.
//
// Operation
// RULE_01: No program execution while stopped.
// RULE_02: Entering stop preserves counters, timers, image.
// RULE_03: Stop asserts command output disable.
// RULE_04: Stop: run indicator off, stop on; the run indicator still blinks in stop while the minimum-blink timer runs.
// RULE_05: Stop-to-run calls startup routine, unmonitored.
// RULE_06: Output disable held throughout start-up.
// RULE_07: Run indicator blinks at least 3 s.
// RULE_08: Stop indicator on during startup routine.
// RULE_09: Startup completion enters run directly.
// RULE_10: After watchdog stop, restart needs cold-start.
// RULE_11: Run repeats main routine, timers active.
// RULE_12: Run releases output disable, run indicator on.
// RULE_13: Up to 3 breakpoints; hit enters hold.
// RULE_14: Hold freezes code and timers, disables outputs.
// RULE_15: Hold blinks run indicator, stop on.
// RULE_16: Over 2 breakpoints refuses single step.
// RULE_17: 100 ms watchdog, cycle monitor force stop.
// RULE_18: Stop drives analog outputs to disabled levels.
// RULE_19: Decentral stations disable outputs, keep reading.
// RULE_20: Start order: clear inputs, startup, clear outputs.
// RULE_21: Cycle: read inputs, main routine, write outputs.
// RULE_22: Overall reset erases user memory only.
// RULE_23: Operator holds reset position about 3 s.
// RULE_24: Mode reported as distinct two-bit code.
`timescale 1ns/1ps
`default_nettype none

module oms_sequencer #(
   parameter int unsigned WATCHDOG_CYCLES = oms_pkg::WATCHDOG_CYC,
   parameter int unsigned RUN_BLINK_CYCLES = oms_pkg::RUN_BLINK_CYC,
   parameter int unsigned BLINK_HALF_CYCLES = oms_pkg::BLINK_HALF_CYC,
   parameter int unsigned MR_HOLD_CYCLES = oms_pkg::MR_HOLD_CYC,
   parameter int unsigned CYCLE_MON_MIN_CYCLES = oms_pkg::CYCLE_MON_MIN_CYC
) (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Operator and configuration.
   input wire logic run_request_in,
   input wire logic memory_reset_position_in,
   input wire logic project_reload_in,
   input wire logic cold_start_routine_present_in,
   input wire logic [31:0] cycle_limit_in,
   input wire logic [1:0] breakpoints_active_in,
   input wire logic step_request_in,
   // Program engine handshake.
   input wire logic phase_done_in,
   input wire logic breakpoint_hit_in,
   input wire logic resume_in,
   input wire logic watchdog_kick_in,
   // Program engine control.
   output oms_pkg::oms_phase_t phase_out,
   output logic timers_enable_out,
   output logic step_grant_out,
   output logic user_memory_erase_out,
   // Outputs and indicators.
   output logic command_output_disable_out,
   output oms_pkg::oms_leds_t leds_out,
   output logic [1:0] mode_out,
   output logic watchdog_stop_out
);

   initial begin
      if (WATCHDOG_CYCLES < 2 || RUN_BLINK_CYCLES < 2 ||
          BLINK_HALF_CYCLES < 1 || MR_HOLD_CYCLES < 2)
         $error("oms_sequencer: timing parameters too small");
   end

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   oms_pkg::oms_mode_t mode;
   oms_pkg::oms_phase_t phase;
   logic wd_latched;
   logic blink_phase;
   logic [31:0] blink_count;
   logic [31:0] cycle_count;
   logic [31:0] mr_count;
   logic mr_armed;
   logic blink_busy;
   logic blink_load;
   logic wd_expired;
   logic cycle_over;
   logic fault;
   logic startup_done;
   logic restart_ok;
   logic erase_now;
   logic wd_run;

   // An erase is a memory-reset position held long enough, or a reload.
   assign erase_now = project_reload_in ||
      (memory_reset_position_in && mr_count == 32'(MR_HOLD_CYCLES - 1));

   // Watchdog restart only via cold start, erase or reload.
   assign restart_ok = !wd_latched || cold_start_routine_present_in ||
      erase_now; // RULE_10

   // Start-up phases and the stop mode carry no watchdog.
   assign wd_run = (mode == oms_pkg::OMS_RUN); // RULE_05
   assign cycle_over = (mode == oms_pkg::OMS_RUN) &&
      (cycle_limit_in >= 32'(CYCLE_MON_MIN_CYCLES)) &&
      (cycle_count >= cycle_limit_in); // RULE_17
   assign fault = wd_expired || cycle_over;
   assign startup_done = (phase == oms_pkg::PH_STARTUP) && phase_done_in;
   assign blink_load = (mode == oms_pkg::OMS_STOP) && run_request_in &&
      restart_ok && !fault;

   // ------------------------------------------------------------------
   // Watchdog and minimum-blink timers
   // ------------------------------------------------------------------
   oms_timer #(.WIDTH(32)) u_watchdog (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(!wd_run || watchdog_kick_in),
      .load_value_in(32'(WATCHDOG_CYCLES)),
      .run_in(wd_run),
      .expired_out(wd_expired),
      .busy_out()
   ); // RULE_17

   oms_timer #(.WIDTH(32)) u_run_blink (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(blink_load),
      .load_value_in(32'(RUN_BLINK_CYCLES)),
      .run_in(1'b1),
      .expired_out(),
      .busy_out(blink_busy)
   ); // RULE_07

   // ------------------------------------------------------------------
   // Mode machine
   // ------------------------------------------------------------------
   // Any fault wins over every other move so stop is always reached.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mode <= oms_pkg::OMS_STOP;
      end else if (fault) begin
         mode <= oms_pkg::OMS_STOP; // RULE_17
      end else begin
         case (mode)
            oms_pkg::OMS_STOP: begin
               if (run_request_in && restart_ok) begin
                  mode <= oms_pkg::OMS_STARTUP; // RULE_05
               end
            end
            oms_pkg::OMS_STARTUP: begin
               if (!run_request_in) begin
                  mode <= oms_pkg::OMS_STOP;
               end else if (startup_done) begin
                  mode <= oms_pkg::OMS_RUN; // RULE_09
               end
            end
            oms_pkg::OMS_RUN: begin
               if (!run_request_in) begin
                  mode <= oms_pkg::OMS_STOP;
               end else if (breakpoint_hit_in &&
                            breakpoints_active_in != 2'h0) begin
                  mode <= oms_pkg::OMS_HOLD; // RULE_13
               end
            end
            default: begin
               if (!run_request_in) begin
                  mode <= oms_pkg::OMS_STOP;
               end else if (resume_in) begin
                  mode <= oms_pkg::OMS_RUN;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Phase ordering
   // ------------------------------------------------------------------
   // Phase moves on the engine's done pulse, except that a start loads PH_CLR_IN and
   // stop or a fault returns it to PH_IDLE; hold freezes it, so images and counters keep their values.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         phase <= oms_pkg::PH_IDLE;
      end else if (fault || mode == oms_pkg::OMS_STOP && !blink_load) begin
         phase <= oms_pkg::PH_IDLE; // RULE_01 RULE_02
      end else if (blink_load) begin
         phase <= oms_pkg::PH_CLR_IN; // RULE_20
      end else if (mode != oms_pkg::OMS_HOLD && phase_done_in) begin
         case (phase)
            oms_pkg::PH_CLR_IN: phase <= oms_pkg::PH_STARTUP; // RULE_20
            oms_pkg::PH_STARTUP: phase <= oms_pkg::PH_CLR_OUT; // RULE_20
            oms_pkg::PH_CLR_OUT: phase <= oms_pkg::PH_READ_IN; // RULE_20
            oms_pkg::PH_READ_IN: phase <= oms_pkg::PH_MAIN; // RULE_21
            oms_pkg::PH_MAIN: phase <= oms_pkg::PH_WRITE_OUT; // RULE_21
            oms_pkg::PH_WRITE_OUT: phase <= oms_pkg::PH_READ_IN; // RULE_11
            default: phase <= oms_pkg::PH_IDLE;
         endcase
      end
   end

   // Cycle-time monitor counts one read-main-write round.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cycle_count <= '0;
      end else if (mode != oms_pkg::OMS_RUN ||
                   (phase == oms_pkg::PH_WRITE_OUT && phase_done_in)) begin
         cycle_count <= '0;
      end else begin
         cycle_count <= cycle_count + 32'h1;
      end
   end

   // Watchdog stop latches; a set in the same cycle as a clear wins.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wd_latched <= 1'b0;
      end else if (wd_expired) begin
         wd_latched <= 1'b1; // RULE_10
      end else if (mode == oms_pkg::OMS_STARTUP || erase_now) begin
         wd_latched <= 1'b0;
      end
   end

   // Memory-reset position is only counted while stopped.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mr_count <= '0;
         mr_armed <= 1'b0;
      end else if (mode != oms_pkg::OMS_STOP || !memory_reset_position_in) begin
         mr_count <= '0;
         mr_armed <= 1'b0;
      end else if (!mr_armed) begin
         mr_count <= mr_count + 32'h1; // RULE_23
         mr_armed <= (mr_count == 32'(MR_HOLD_CYCLES - 1));
      end
   end

   // Blink divider for the run indicator.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         blink_count <= '0;
         blink_phase <= 1'b0;
      end else if (blink_count >= 32'(BLINK_HALF_CYCLES - 1)) begin
         blink_count <= '0;
         blink_phase <= !blink_phase;
      end else begin
         blink_count <= blink_count + 32'h1;
      end
   end

   // ------------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------------
   // Outputs are enabled only in run; everywhere else disable is held.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         command_output_disable_out <= 1'b1;
         leds_out <= '{run_led: 1'b0, stop_led: 1'b1};
         mode_out <= oms_pkg::MODE_STOP;
         timers_enable_out <= 1'b0;
         user_memory_erase_out <= 1'b0;
         step_grant_out <= 1'b0;
         watchdog_stop_out <= 1'b0;
      end else begin
         // Analog and decentral consumers take their disabled levels from
         // this one flag, so no per-kind output logic lives here.
         command_output_disable_out <= // RULE_03 RULE_06 RULE_18
            (mode != oms_pkg::OMS_RUN); // RULE_12 RULE_14
         timers_enable_out <= (mode == oms_pkg::OMS_RUN); // RULE_11 RULE_14
         user_memory_erase_out <= erase_now &&
            mode == oms_pkg::OMS_STOP; // RULE_22
         step_grant_out <= (mode == oms_pkg::OMS_HOLD) && step_request_in &&
            (breakpoints_active_in <=
             2'(oms_pkg::STEP_MAX_BREAKPOINTS)); // RULE_16
         watchdog_stop_out <= wd_latched;
         case (mode)
            oms_pkg::OMS_STOP: begin
               mode_out <= oms_pkg::MODE_STOP; // RULE_24
               leds_out <= '{run_led: blink_busy && blink_phase,
                             stop_led: 1'b1}; // RULE_04 RULE_07
            end
            oms_pkg::OMS_STARTUP: begin
               mode_out <= oms_pkg::MODE_STARTUP;
               leds_out <= '{run_led: blink_phase,
                             stop_led: 1'b1}; // RULE_07 RULE_08
            end
            oms_pkg::OMS_RUN: begin
               mode_out <= oms_pkg::MODE_RUN;
               leds_out <= '{run_led: blink_busy ? blink_phase : 1'b1,
                             stop_led: 1'b0}; // RULE_07 RULE_12
            end
            default: begin
               mode_out <= oms_pkg::MODE_HOLD;
               leds_out <= '{run_led: blink_phase,
                             stop_led: 1'b1}; // RULE_15
            end
         endcase
      end
   end

   assign phase_out = phase;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   stop_no_exec_a: assert property ((mode == oms_pkg::OMS_STOP && !blink_load)
      |=> phase == oms_pkg::PH_IDLE) // RULE_01
      else $error("program phase active in stop");
   stop_disable_a: assert property (mode == oms_pkg::OMS_STOP
      |=> command_output_disable_out && leds_out.stop_led) // RULE_03
      else $error("stop without output disable");
   run_enable_a: assert property (mode == oms_pkg::OMS_RUN
      |=> !command_output_disable_out && !leds_out.stop_led) // RULE_12
      else $error("run without output enable");
   startup_order_a: assert property (blink_load && !fault
      |=> phase == oms_pkg::PH_CLR_IN) // RULE_20
      else $error("start not begun with input clear");
   startup_run_a: assert property (startup_done && !fault && run_request_in
      && mode == oms_pkg::OMS_STARTUP |=> mode == oms_pkg::OMS_RUN) // RULE_09
      else $error("startup did not enter run");
   cycle_order_a: assert property (phase == oms_pkg::PH_MAIN && phase_done_in
      && mode == oms_pkg::OMS_RUN && !fault
      |=> phase == oms_pkg::PH_WRITE_OUT) // RULE_21
      else $error("cycle order broken");
   wd_stop_a: assert property (wd_expired |=> mode == oms_pkg::OMS_STOP
      ##1 watchdog_stop_out) // RULE_17
      else $error("watchdog did not force stop");
   wd_hold_a: assert property (wd_latched && !cold_start_routine_present_in
      && !erase_now && mode == oms_pkg::OMS_STOP
      |=> mode == oms_pkg::OMS_STOP) // RULE_10
      else $error("left watchdog stop illegally");
   blink_min_a: assert property ($rose(blink_load) // RULE_07
      |=> blink_busy [*8])
      else $error("run blink window too short");
   hold_freeze_a: assert property (mode == oms_pkg::OMS_HOLD
      |=> !timers_enable_out && command_output_disable_out) // RULE_14
      else $error("hold did not freeze");
   step_refuse_a: assert property (breakpoints_active_in == 2'h3
      |=> !step_grant_out) // RULE_16
      else $error("single step granted with three breakpoints");

   run_c: cover property (mode == oms_pkg::OMS_STARTUP
      ##[1:50] mode == oms_pkg::OMS_RUN);
   hold_c: cover property (mode == oms_pkg::OMS_RUN
      ##1 mode == oms_pkg::OMS_HOLD);
   wd_c: cover property (wd_expired);
   erase_c: cover property (user_memory_erase_out);

endmodule : oms_sequencer
`default_nettype wire

// ### bench/oms_engine_model.sv
// Program engine stand-in that answers each ordered phase with a done pulse.
// Assumes the sequencer holds phase steady until it has seen that pulse.
`timescale 1ns/1ps
`default_nettype none

module oms_engine_model (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Sequencer side.
   input wire oms_pkg::oms_phase_t phase_in,
   output logic phase_done_out,
   output logic watchdog_kick_out,
   // Test control.
   input wire logic [7:0] delay_in,
   input wire logic kick_en_in
);
   oms_pkg::oms_phase_t last;
   logic [7:0] cnt;
   logic armed;

   // ----------------------------------------------------------------
   // Phase answer
   // ----------------------------------------------------------------
   // A new phase restarts the count, so a large delay mimics a long
   // routine; an idle phase is never answered, as nothing runs in stop.
   always_ff @(negedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         last <= oms_pkg::PH_IDLE;
         cnt <= 8'h00;
         armed <= 1'b0;
         phase_done_out <= 1'b0;
         watchdog_kick_out <= 1'b0;
      end else begin
         phase_done_out <= 1'b0;
         watchdog_kick_out <= 1'b0;
         last <= phase_in;
         cnt <= cnt + 8'h01;
         if (phase_in != last) begin
            cnt <= 8'h01;
            armed <= (phase_in != oms_pkg::PH_IDLE);
         end else if (armed && cnt >= delay_in) begin
            armed <= 1'b0;
            phase_done_out <= 1'b1;
            // The main routine retriggers the watchdog when allowed.
            watchdog_kick_out <= kick_en_in && (phase_in == oms_pkg::PH_MAIN);
         end
      end
   end
endmodule : oms_engine_model
`default_nettype wire

// ### bench/oms_sequencer_tb.sv
// Self-checking bench for the operating-mode sequencer.
// Assumes the engine model answers phases; counts are shortened.
`timescale 1ns/1ps
`default_nettype none

module oms_sequencer_tb;
   localparam int WD = 50;
   localparam int BLINK = 20;
   localparam int MR = 10;
   localparam int LIMIT_CYC = 4000;
   localparam logic [2:0] EXP_PH [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
      3'h6, 3'h4};
   logic sys_clk_in, reset_n_in, run_req, mr_pos, reload, cold_ok;
   logic step_req, bp_hit, resume, done, kick, kick_en;
   logic tmr_en, step_gnt, erase, cod, wd_stop;
   logic [31:0] cyc_lim;
   logic [1:0] bp_act, mode;
   logic [7:0] delay;
   logic [2:0] last_ph = 3'h0;
   logic [2:0] ph_q[$];
   oms_pkg::oms_phase_t phase;
   oms_pkg::oms_leds_t leds;
   int n_errors = 0;
   int n_checks = 0;
   int n_erase = 0;

   oms_sequencer #(.WATCHDOG_CYCLES(WD), .RUN_BLINK_CYCLES(BLINK),
      .BLINK_HALF_CYCLES(2), .MR_HOLD_CYCLES(MR),
      .CYCLE_MON_MIN_CYCLES(8)) dut_u (
      .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .run_request_in(run_req), .memory_reset_position_in(mr_pos),
      .project_reload_in(reload), .cold_start_routine_present_in(cold_ok),
      .cycle_limit_in(cyc_lim), .breakpoints_active_in(bp_act),
      .step_request_in(step_req), .phase_done_in(done),
      .breakpoint_hit_in(bp_hit), .resume_in(resume),
      .watchdog_kick_in(kick), .phase_out(phase), .timers_enable_out(tmr_en),
      .step_grant_out(step_gnt), .user_memory_erase_out(erase),
      .command_output_disable_out(cod), .leds_out(leds), .mode_out(mode),
      .watchdog_stop_out(wd_stop));

   oms_engine_model eng_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .phase_in(phase), .phase_done_out(done), .watchdog_kick_out(kick),
      .delay_in(delay), .kick_en_in(kick_en));

   // ----------------------------------------------------------------
   // Clock, monitors and helpers
   // ----------------------------------------------------------------
   // Free-running 10 MHz clock.
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   // Records each phase change and counts erase pulses.
   always @(negedge sys_clk_in) begin
      if (phase !== last_ph) ph_q.push_back(phase);
      last_ph = phase;
      if (erase === 1'b1) n_erase++;
   end

   task automatic end_sim();
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : tick

   // Bounded wait for a mode; a missing mode shows as a mismatch.
   task automatic wait_mode(input logic [1:0] m, input int lim,
      input string what);
      int i;
      i = 0;
      while (mode !== m && i < lim) begin
         tick(1);
         i++;
      end
      chk(mode, m, what);
   endtask : wait_mode

   // Watches the run indicator for toggles over n cycles.
   task automatic blinks(input int n, input string what);
      int t;
      logic p;
      t = 0;
      p = leds.run_led;
      repeat (n) begin
         tick(1);
         if (leds.run_led !== p) t++;
         p = leds.run_led;
      end
      chk(t > 0, 1'b1, what);
   endtask : blinks

   // Watchdog: a hang counts as a mismatch and ends the run.
   initial begin
      #(LIMIT_CYC * 100);
      n_errors++;
      $display("ERROR t=%0t run did not finish", $time);
      end_sim();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      reset_n_in = 1'b0;
      {run_req, mr_pos, reload, cold_ok, step_req, bp_hit, resume} = 7'h00;
      cyc_lim = 32'h0;
      bp_act = 2'h0;
      delay = 8'h3C;
      kick_en = 1'b0;
      tick(10);
      reset_n_in = 1'b1;
      tick(2);
      chk(mode, oms_pkg::MODE_STOP, "mode after reset");
      chk(cod, 1'b1, "outputs disabled in stop");
      chk(leds, 2'h1, "leds in stop");
      chk(phase, oms_pkg::PH_IDLE, "no program in stop");
      // Start-up far longer than the watchdog must still complete.
      ph_q.delete();
      run_req = 1'b1;
      wait_mode(oms_pkg::MODE_STARTUP, 4, "enter startup");
      chk(phase, oms_pkg::PH_CLR_IN, "inputs cleared first");
      blinks(BLINK / 2, "run led blinks in startup");
      chk(cod, 1'b1, "outputs disabled in startup");
      chk(leds.stop_led, 1'b1, "stop led during startup");
      wait_mode(oms_pkg::MODE_RUN, 200, "slow startup reaches run");
      delay = 8'h01;
      kick_en = 1'b1;
      tick(3);
      chk(cod, 1'b0, "outputs enabled in run");
      chk(leds, 2'h2, "leds in run");
      chk(tmr_en, 1'b1, "timers active in run");
      tick(40);
      for (int i = 0; i < 7; i++) chk(ph_q[i], EXP_PH[i], "phase order");
      chk(ph_q.size() > 12, 1'b1, "main cycle repeats");
      // Breakpoint, hold and single-step refusal.
      bp_act = 2'h3;
      bp_hit = 1'b1;
      tick(1);
      bp_hit = 1'b0;
      wait_mode(oms_pkg::MODE_HOLD, 4, "breakpoint enters hold");
      tick(2);
      chk(cod, 1'b1, "outputs disabled in hold");
      chk(tmr_en, 1'b0, "timers frozen in hold");
      chk(leds.stop_led, 1'b1, "stop led in hold");
      blinks(8, "run led blinks in hold");
      step_req = 1'b1;
      tick(3);
      chk(step_gnt, 1'b0, "step refused with three");
      bp_act = 2'h2;
      tick(3);
      chk(step_gnt, 1'b1, "step allowed with two");
      step_req = 1'b0;
      resume = 1'b1;
      tick(1);
      resume = 1'b0;
      wait_mode(oms_pkg::MODE_RUN, 4, "resume to run");
      // Missing kicks: watchdog stop, restart only with cold start.
      kick_en = 1'b0;
      wait_mode(oms_pkg::MODE_STOP, WD + 30, "watchdog forces stop");
      tick(2);
      chk(wd_stop, 1'b1, "watchdog stop latched");
      chk(phase, oms_pkg::PH_IDLE, "no program after stop");
      tick(20);
      chk(mode, oms_pkg::MODE_STOP, "restart refused");
      run_req = 1'b0;
      cold_ok = 1'b1;
      kick_en = 1'b1;
      tick(2);
      run_req = 1'b1;
      wait_mode(oms_pkg::MODE_RUN, 20, "cold start restarts");
      blinks(8, "blink outlasts short startup");
      // Second watchdog stop cleared by a project reload.
      cold_ok = 1'b0;
      kick_en = 1'b0;
      wait_mode(oms_pkg::MODE_STOP, WD + 30, "second watchdog stop");
      tick(10);
      kick_en = 1'b1;
      reload = 1'b1;
      tick(1);
      reload = 1'b0;
      tick(3);
      chk(n_erase, 1, "reload erases memory");
      wait_mode(oms_pkg::MODE_RUN, 20, "reload restarts");
      run_req = 1'b0;
      wait_mode(oms_pkg::MODE_STOP, 4, "switch to stop");
      tick(BLINK + 5);
      chk(leds, 2'h1, "leds settle in stop");
      // Memory-reset position: short hold ignored, full hold erases.
      mr_pos = 1'b1;
      tick(MR - 5);
      mr_pos = 1'b0;
      tick(3);
      chk(n_erase, 1, "short hold no erase");
      mr_pos = 1'b1;
      tick(MR + 3);
      mr_pos = 1'b0;
      tick(3);
      chk(n_erase, 2, "full hold erases");
      // Slow cycles against the cycle-time limit.
      cyc_lim = 32'h14;
      delay = 8'h0A;
      run_req = 1'b1;
      wait_mode(oms_pkg::MODE_RUN, 40, "run before monitor");
      wait_mode(oms_pkg::MODE_STOP, 45, "cycle monitor stops");
      chk(cod, 1'b1, "outputs disabled");
      end_sim();
   end
endmodule : oms_sequencer_tb
`default_nettype wire
